/* File: logic/tcdb_pkg.sv */
package tcdb_pkg;

    // Register byte offsets on the Wishbone bus
    localparam logic [7:0] OFS_COUNT = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_CAPCMP = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0C;
    localparam logic [7:0] OFS_FUNCTION = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // Control register fields
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_CAP_IRQ_BIT = 1;
    localparam int CTL_TC_HALF_BIT = 2;
    localparam int CTL_SOFT_REF_BIT = 3;
    localparam int CTL_CHAIN_BIT = 4;
    localparam int CTL_WIDTH = 5;

    // Function register fields: select in [1:0], mode in [3:2]
    localparam int FN_SEL_LSB = 0;
    localparam int FN_MODE_LSB = 2;
    localparam int FN_WIDTH = 4;

    // Mode bit positions inside the two-bit mode field
    localparam int MODE_IRQ_CMP_BIT = 0;
    localparam int MODE_CMP_LT_BIT = 1;

    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [CTL_WIDTH-1:0] CTL_RESET = 5'h00;
    localparam logic [FN_WIDTH-1:0] FN_RESET = 4'h0;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    // Functions of the block
    typedef enum logic [1:0] {FUNC_TIMER, FUNC_COUNTER, FUNC_DEADBAND, FUNC_NONE} func_e;

    // Dead band kill types
    typedef enum logic [1:0] {KILL_RESTART, KILL_DISABLE, KILL_ASYNC, KILL_RESERVED} kill_e;

    // Wishbone classic request and response
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_s;

    // Chaining signals between neighbouring blocks
    typedef struct packed {
        logic en;
        logic carry;
        logic cmp;
    } chain_s;

endpackage

/* File: logic/timer_counter_deadband_block.sv */
// Behaviour
// [RULE1] Disabled period write also loads count
// [RULE2] Count down, reload period after zero
// [RULE3] Timer terminal count on primary, full/half
// [RULE4] Data input rising edge captures count
// [RULE5] Running count read captures; sources ORed
// [RULE6] Timer compare on auxiliary; capture overwrites compare
// [RULE7] Mode bit1 compare type, bit0 irq source
// [RULE8] Chain blocks via carry, compare, enable
// [RULE9] Software: no capture at 48 MHz, no writes
// [RULE10] Rising terminal count or compare raises interrupt
// [RULE11] Capture interrupt when enabled at latch time
// [RULE12] Counter gate high counts and reloads only
// [RULE13] Counter compare primary, terminal count auxiliary
// [RULE14] Software reads count only while disabled
// [RULE15] Dead band phases never overlap, period gap
// [RULE16] Reference from previous block or soft bit
// [RULE17] Kill forces both phases low immediately
// [RULE18] Kill modes restart, disable, async, reserved
// [RULE19] Edge starts countdown; zero raises phase
// [RULE20] Rising edge primary, falling edge auxiliary
// [RULE21] Software: no chaining, no zero dead time
// [RULE22] Short reference half keeps phase low
// [RULE23] Dead band interrupt follows killed primary phase
// [RULE24] Per-block interrupt mask bit
// [RULE25] Reset leaves block disabled, outputs low
`timescale 1ns/1ps
`default_nettype none

module timer_counter_deadband_block
    import tcdb_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Wishbone slave
    input wire wb_req_s wb_in,
    output wb_rsp_s wb_out,
    // Neighbour block signals
    input wire logic data_in,
    input wire logic prev_primary_in,
    input wire chain_s chain_in,
    output chain_s chain_out,
    // Function outputs
    output logic primary_out,
    output logic aux_out,
    output logic irq_out
);

    // Software visible state
    logic [7:0] count_value_reg_r;
    logic [7:0] period_value_reg_r;
    logic [7:0] capture_compare_reg_r;
    logic [CTL_WIDTH-1:0] control_r;
    logic [FN_WIDTH-1:0] function_r;
    logic irq_mask_r;

    // Bus handshake
    logic ack_r;
    logic [31:0] rd_dat_r;
    logic req;
    logic wr_now;
    logic rd_now;
    logic [31:0] rd_mux;

    // Decoded configuration
    func_e func;
    kill_e kill_type;
    logic enable;
    logic cmp_lt;
    logic irq_on_cmp;
    logic chained;

    // Counter datapath
    logic advance;
    logic at_zero;
    logic tc;
    logic cmp;
    logic cap_src;
    logic cap_prev_r;
    logic cap_fire;
    logic sw_cap;

    // Dead band state
    logic ref_sel;
    logic ref_prev_r;
    logic ref_rise;
    logic ref_fall;
    logic db_running_r;
    logic db_dir_r;
    logic phase_a_r;
    logic phase_b_r;
    logic kill_prev_r;
    logic db_kill_out;
    logic db_hold;
    logic kill_disable;

    // Interrupt source
    logic irq_src;
    logic irq_src_prev_r;
    logic cap_irq_r;

    assign func = func_e'(function_r[FN_SEL_LSB +: 2]);
    assign kill_type = kill_e'(function_r[FN_MODE_LSB +: 2]);
    assign enable = control_r[CTL_ENABLE_BIT];
    assign chained = control_r[CTL_CHAIN_BIT];
    assign cmp_lt = function_r[FN_MODE_LSB + MODE_CMP_LT_BIT]; // RULE7
    assign irq_on_cmp = function_r[FN_MODE_LSB + MODE_IRQ_CMP_BIT]; // RULE7

    // A request is answered one cycle after it is seen; writes land on the ack edge
    assign req = wb_in.cyc & wb_in.stb;
    assign wr_now = req & ack_r & wb_in.we & wb_in.sel[0];
    assign rd_now = req & ack_r & ~wb_in.we;
    assign wb_out.ack = ack_r;
    assign wb_out.dat = rd_dat_r;

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_mux = WORD_ZERO;
        case (wb_in.adr)
            OFS_COUNT: rd_mux[7:0] = count_value_reg_r;
            OFS_PERIOD: rd_mux[7:0] = period_value_reg_r;
            OFS_CAPCMP: rd_mux[7:0] = capture_compare_reg_r;
            OFS_CONTROL: rd_mux[CTL_WIDTH-1:0] = control_r;
            OFS_FUNCTION: rd_mux[FN_WIDTH-1:0] = function_r;
            OFS_IRQ_MASK: rd_mux[0] = irq_mask_r;
            OFS_STATUS: rd_mux[3:0] = {db_running_r, irq_src, aux_out, primary_out};
            default: rd_mux = WORD_ZERO;
        endcase
    end

    // Read data is registered in the cycle before ack so it is stable while ack is high
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            rd_dat_r <= WORD_ZERO;
        end else if (req & ~ack_r) begin
            rd_dat_r <= rd_mux;
        end
    end

    // Chaining: an upper block advances only when the lower one is at terminal count
    assign advance = enable & (~chained | (chain_in.en & chain_in.carry)) // RULE8
                     & ((func == FUNC_TIMER) | (func == FUNC_COUNTER & data_in)); // RULE12
    assign at_zero = (count_value_reg_r == BYTE_RESET);
    assign tc = enable & at_zero & (~chained | chain_in.carry); // RULE8
    assign chain_out.carry = tc;
    assign chain_out.en = enable;

    // Compare; in a chain an equal upper byte defers to the lower block's result
    always_comb begin
        if (cmp_lt) begin
            cmp = (count_value_reg_r < capture_compare_reg_r); // RULE7
        end else begin
            cmp = (count_value_reg_r <= capture_compare_reg_r); // RULE7
        end
        if (chained && count_value_reg_r == capture_compare_reg_r) begin
            cmp = chain_in.cmp; // RULE8
        end
    end
    assign chain_out.cmp = cmp;

    // Capture: hardware and software sources are ORed, then edge detected
    assign sw_cap = rd_now & (wb_in.adr == OFS_COUNT) & enable & (func == FUNC_TIMER); // RULE5
    assign cap_src = (func == FUNC_TIMER) & enable & (data_in | sw_cap); // RULE5
    assign cap_fire = cap_src & ~cap_prev_r; // RULE4

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            cap_prev_r <= 1'b0;
        end else begin
            cap_prev_r <= cap_src; // RULE5
        end
    end

    // Dead band reference selection and edge detection
    assign ref_sel = control_r[CTL_SOFT_REF_BIT] ? control_r[CTL_SOFT_REF_BIT] : prev_primary_in; // RULE16
    assign ref_rise = ref_sel & ~ref_prev_r;
    assign ref_fall = ~ref_sel & ref_prev_r;
    assign kill_disable = (func == FUNC_DEADBAND) & enable & data_in & (kill_type == KILL_DISABLE); // RULE18

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            ref_prev_r <= 1'b0;
            kill_prev_r <= 1'b0;
        end else begin
            ref_prev_r <= ref_sel;
            kill_prev_r <= data_in;
        end
    end

    // Count register: period load while disabled, count or dead band countdown while enabled
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            count_value_reg_r <= BYTE_RESET; // RULE25
        end else if (!enable) begin
            if (wr_now && wb_in.adr == OFS_PERIOD) begin
                count_value_reg_r <= wb_in.dat[7:0]; // RULE1
            end else if (wr_now && wb_in.adr == OFS_COUNT) begin
                count_value_reg_r <= wb_in.dat[7:0];
            end
        end else if (func == FUNC_DEADBAND) begin
            if (db_hold) begin
                count_value_reg_r <= period_value_reg_r;
            end else if (ref_rise || ref_fall) begin
                count_value_reg_r <= period_value_reg_r; // RULE19
            end else if (db_running_r && !at_zero) begin
                count_value_reg_r <= count_value_reg_r - 8'h01;
            end
        end else if (advance) begin
            if (at_zero) begin
                count_value_reg_r <= period_value_reg_r; // RULE2
            end else begin
                count_value_reg_r <= count_value_reg_r - 8'h01; // RULE2
            end
        end
    end

    // Period register
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            period_value_reg_r <= BYTE_RESET;
        end else if (wr_now && wb_in.adr == OFS_PERIOD) begin
            period_value_reg_r <= wb_in.dat[7:0];
        end
    end

    // Capture/compare register; a capture overwrites the compare value
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            capture_compare_reg_r <= BYTE_RESET;
        end else if (cap_fire) begin
            capture_compare_reg_r <= count_value_reg_r; // RULE4 RULE6
        end else if (rd_now && wb_in.adr == OFS_COUNT && !enable) begin
            capture_compare_reg_r <= count_value_reg_r; // RULE14
        end else if (wr_now && wb_in.adr == OFS_CAPCMP && !enable) begin
            capture_compare_reg_r <= wb_in.dat[7:0]; // RULE9
        end
    end

    // Control: a disable-type kill clears enable and wins over a software write
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            control_r <= CTL_RESET; // RULE25
        end else if (kill_disable) begin
            control_r[CTL_ENABLE_BIT] <= 1'b0; // RULE18
        end else if (wr_now && wb_in.adr == OFS_CONTROL) begin
            control_r <= wb_in.dat[CTL_WIDTH-1:0];
        end
    end

    // Function and mask registers
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            function_r <= FN_RESET;
            irq_mask_r <= 1'b0;
        end else if (wr_now) begin
            if (wb_in.adr == OFS_FUNCTION) begin
                function_r <= wb_in.dat[FN_WIDTH-1:0];
            end
            if (wb_in.adr == OFS_IRQ_MASK) begin
                irq_mask_r <= wb_in.dat[0]; // RULE24
            end
        end
    end

    // Restart kill holds state in reset; async kill leaves it alone
    assign db_hold = data_in & (kill_type == KILL_RESTART); // RULE18

    // Dead band phase machine
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            db_running_r <= 1'b0;
            db_dir_r <= 1'b0;
            phase_a_r <= 1'b0;
            phase_b_r <= 1'b0;
        end else if (!enable || func != FUNC_DEADBAND || db_hold) begin
            db_running_r <= 1'b0; // RULE19
            phase_a_r <= 1'b0;
            phase_b_r <= 1'b0;
        end else if (ref_rise || ref_fall) begin
            db_running_r <= 1'b1; // RULE19
            db_dir_r <= ref_rise; // RULE20
            phase_a_r <= 1'b0; // RULE22
            phase_b_r <= 1'b0; // RULE15
        end else if (db_running_r && at_zero) begin
            db_running_r <= 1'b0; // RULE19
            phase_a_r <= db_dir_r; // RULE20
            phase_b_r <= ~db_dir_r; // RULE20
        end
    end

    // Kill masks outputs with no clock; async kill stretches low by one cycle
    assign db_kill_out = data_in | ((kill_type == KILL_ASYNC) & kill_prev_r); // RULE17 RULE18

    // Output routing per function
    always_comb begin
        case (func)
            FUNC_TIMER: begin
                primary_out = control_r[CTL_TC_HALF_BIT] ? (tc & ~mclk_in) : tc; // RULE3
                aux_out = enable & cmp; // RULE6
                irq_src = irq_on_cmp ? aux_out : primary_out; // RULE10
            end
            FUNC_COUNTER: begin
                primary_out = enable & cmp; // RULE13
                aux_out = tc; // RULE13
                irq_src = irq_on_cmp ? primary_out : aux_out; // RULE10
            end
            FUNC_DEADBAND: begin
                primary_out = phase_a_r & ~db_kill_out; // RULE15 RULE17
                aux_out = phase_b_r & ~db_kill_out; // RULE15 RULE17
                irq_src = primary_out; // RULE23
            end
            default: begin
                primary_out = 1'b0;
                aux_out = 1'b0;
                irq_src = 1'b0;
            end
        endcase
    end

    // Edge detect of the interrupt source; the half-width pulse is sampled before it closes
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            irq_src_prev_r <= 1'b0;
            cap_irq_r <= 1'b0;
        end else begin
            irq_src_prev_r <= irq_src;
            cap_irq_r <= cap_fire & control_r[CTL_CAP_IRQ_BIT]; // RULE11
        end
    end

    // Interrupt pulse, gated by the block mask
    assign irq_out = irq_mask_r & ((irq_src & ~irq_src_prev_r) | cap_irq_r); // RULE10 RULE24

endmodule

`default_nettype wire

/* File: test/tcdb_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module tcdb_chk
    import tcdb_pkg::*;
(
    // Clock, reset and bus
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire wb_req_s wb_in,
    input wire wb_rsp_s wb_out,
    // Neighbour and function signals
    input wire logic data_in,
    input wire logic prev_primary_in,
    input wire chain_s chain_in,
    input wire chain_s chain_out,
    input wire logic primary_out,
    input wire logic aux_out,
    input wire logic irq_out
);
    logic [3:0] fn_r;
    logic [4:0] ctl_r;
    logic msk_r;
    logic wr, tmr, cnt, db;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // Shadow of setup writes; a kill may clear enable inside, so a high enable is trusted only in the timer and counter checks
    assign wr = wb_in.cyc && wb_in.stb && wb_in.we && wb_in.sel[0] && wb_out.ack;
    assign tmr = fn_r[1:0] == 2'h0;
    assign cnt = fn_r[1:0] == 2'h1 && ctl_r[0];
    assign db = fn_r[1:0] == 2'h2;
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            fn_r <= 4'h0;
            ctl_r <= 5'h00;
            msk_r <= 1'b0;
        end else if (wr) begin
            if (wb_in.adr == OFS_FUNCTION) fn_r <= wb_in.dat[3:0];
            if (wb_in.adr == OFS_CONTROL) ctl_r <= wb_in.dat[4:0];
            if (wb_in.adr == OFS_IRQ_MASK) msk_r <= wb_in.dat[0];
        end
    end
    property p_tmr_pri; tmr |-> !primary_out || chain_out.carry; endproperty
    a_tmr_pri: assert property (p_tmr_pri) else $error("timer primary without count end");
    property p_tmr_aux; tmr && ctl_r[0] |-> aux_out == chain_out.cmp; endproperty
    a_tmr_aux: assert property (p_tmr_aux) else $error("timer aux not compare");
    property p_cnt_out; cnt |-> aux_out == chain_out.carry && primary_out == chain_out.cmp; endproperty
    a_cnt_out: assert property (p_cnt_out) else $error("counter outputs swapped");
    property p_gate; cnt && $past(cnt) && !$past(data_in) |-> $stable(chain_out.carry); endproperty
    a_gate: assert property (p_gate) else $error("counter moved with gate low");
    property p_en; !ctl_r[0] |-> !chain_out.en; endproperty
    a_en: assert property (p_en) else $error("chain enable without block enable");
    property p_ovl; db |-> !(primary_out && aux_out); endproperty
    a_ovl: assert property (p_ovl) else $error("dead band phases overlap");
    property p_kill; db && data_in |-> !primary_out && !aux_out; endproperty
    a_kill: assert property (p_kill) else $error("kill did not force outputs low");
    property p_db_irq; db && irq_out |-> $rose(primary_out); endproperty
    a_db_irq: assert property (p_db_irq) else $error("dead band irq not from primary rise");
    property p_mask; !msk_r |-> !irq_out; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt seen");
    property p_rst; $rose(reset_n_in) |-> !primary_out && !aux_out && !irq_out && !wb_out.ack; endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule
bind timer_counter_deadband_block tcdb_chk u_tcdb_chk (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .wb_in(wb_in), .wb_out(wb_out), .data_in(data_in), .prev_primary_in(prev_primary_in),
    .chain_in(chain_in), .chain_out(chain_out), .primary_out(primary_out), .aux_out(aux_out),
    .irq_out(irq_out));
`default_nettype wire

/* File: test/tcdb_nbr.sv */
`timescale 1ns/1ps
`default_nettype none
module tcdb_nbr
    import tcdb_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Reference high and low lengths in clocks; zero high length parks it low
    input wire logic [7:0] hi_in,
    input wire logic [7:0] lo_in,
    // Toward the block
    output logic ref_out,
    output chain_s chain_out
);
    logic [7:0] ph_r;
    logic [7:0] low_r;
    // Previous block acting as a waveform source for the reference
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || hi_in == 8'h00) begin
            ph_r <= 8'h00;
            ref_out <= 1'b0;
        end else if (ph_r == 8'h00) begin
            ref_out <= !ref_out;
            ph_r <= (ref_out ? lo_in : hi_in) - 8'h01;
        end else begin
            ph_r <= ph_r - 8'h01;
        end
    end
    // Lower chained byte: free running, so its carry is a short pulse
    always_ff @(posedge clk_in) begin
        low_r <= rst_n_in ? low_r + 8'h01 : 8'h00;
    end
    assign chain_out = '{en: 1'b1, carry: low_r[1:0] == 2'h3, cmp: low_r[2]};
endmodule
`default_nettype wire

/* File: test/timer_counter_deadband_block_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_counter_deadband_block_bench
    import tcdb_pkg::*;
();
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    wb_req_s wb_in = '0;
    wb_rsp_s wb_out;
    logic data_in = 1'b0;
    logic prev_primary_in, primary_out, aux_out, irq_out, pp, pa;
    chain_s chain_in, chain_out;
    logic [7:0] hi = 8'h00;
    logic [7:0] lo = 8'h00;
    logic [31:0] rd;
    int n_errors = 0;
    int comparisons = 0;
    int seed = 53950;
    int p, k, m, c1, n0, a0, n_pri = 0, n_aux = 0, n_irq = 0;
    longint t1, t2;
    timer_counter_deadband_block u_timer_counter_deadband_block (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .wb_in(wb_in), .wb_out(wb_out), .data_in(data_in), .prev_primary_in(prev_primary_in),
        .chain_in(chain_in), .chain_out(chain_out), .primary_out(primary_out), .aux_out(aux_out),
        .irq_out(irq_out));
    tcdb_nbr u_tcdb_nbr (.clk_in(mclk_in), .rst_n_in(reset_n_in), .hi_in(hi), .lo_in(lo),
        .ref_out(prev_primary_in), .chain_out(chain_in));
    initial begin
        forever #20 mclk_in = ~mclk_in;
    end
    // Rising edges of primary and aux, counted from pre-edge values; irq counted per high sample
    always @(posedge mclk_in) begin
        n_pri += int'(primary_out === 1'b1 && pp !== 1'b1);
        n_aux += int'(aux_out === 1'b1 && pa !== 1'b1);
        n_irq += int'(irq_out === 1'b1);
        pp = primary_out;
        pa = aux_out;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One classic cycle; waits for ack under a bound
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int t;
        t = 0;
        @(posedge mclk_in);
        wb_in <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
        do begin
            @(posedge mclk_in);
            t++;
        end while (wb_out.ack !== 1'b1 && t < 20);
        chk("ack", {31'h0, wb_out.ack}, 32'h1);
        rd = wb_out.dat;
        wb_in <= '0;
    endtask
    task automatic hw_cap(output longint t);
        @(posedge mclk_in);
        data_in <= 1'b1;
        @(posedge mclk_in);
        t = $time;
        data_in <= 1'b0;
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            bus(1'b0, 8'(a * 4), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        // Timer: load, hardware and software capture
        p = 3 + $unsigned($random(seed)) % 20;
        bus(1'b1, OFS_PERIOD, p);
        bus(1'b0, OFS_COUNT, 32'h0);
        chk("count load", rd, p);
        bus(1'b0, OFS_CAPCMP, 32'h0);
        chk("idle capture", rd, p);
        bus(1'b1, OFS_CONTROL, 32'h1);
        hw_cap(t1);
        bus(1'b0, OFS_CAPCMP, 32'h0);
        c1 = rd;
        repeat ($unsigned($random(seed)) % 40) @(posedge mclk_in);
        hw_cap(t2);
        bus(1'b0, OFS_CAPCMP, 32'h0);
        k = int'((t2 - t1) / 40);
        chk("hw capture", rd, (c1 + 64 * (p + 1) - k) % (p + 1));
        bus(1'b0, OFS_COUNT, 32'h0);
        c1 = rd;
        bus(1'b0, OFS_CAPCMP, 32'h0);
        chk("sw capture", rd, (c1 + p) % (p + 1));
        @(posedge mclk_in);
        data_in <= 1'b1;
        bus(1'b0, OFS_CAPCMP, 32'h0);
        c1 = rd;
        bus(1'b0, OFS_COUNT, 32'h0);
        bus(1'b0, OFS_CAPCMP, 32'h0);
        chk("masked capture", rd, c1);
        data_in <= 1'b0;
        // Counter in every mode; compare register written only while disabled
        for (m = 0; m < 4; m++) begin
            bus(1'b1, OFS_CONTROL, 32'h0);
            p = 3 + $unsigned($random(seed)) % 20;
            bus(1'b1, OFS_PERIOD, p);
            bus(1'b1, OFS_CAPCMP, p);
            bus(1'b1, OFS_FUNCTION, FUNC_COUNTER | (m << 2));
            bus(1'b1, OFS_IRQ_MASK, !m[0]);
            bus(1'b1, OFS_CONTROL, 32'h1);
            @(negedge mclk_in);
            chk("counter compare", primary_out, !m[1]);
            n0 = n_irq;
            k = $unsigned($random(seed)) % 60;
            @(posedge mclk_in);
            data_in <= 1'b1;
            repeat (k) @(posedge mclk_in);
            data_in <= 1'b0;
            repeat (2) @(posedge mclk_in);
            chk("tc irqs", n_irq - n0, m[0] ? 0 : (k < p ? 0 : (k - p) / (p + 1) + 1));
            bus(1'b1, OFS_CONTROL, 32'h0);
            bus(1'b0, OFS_COUNT, 32'h0);
            chk("gated count", rd, (p + 64 * (p + 1) - k) % (p + 1));
        end
        // Dead band with restart, disable and async kill types; period never zero
        p = 3 + $unsigned($random(seed)) % 10;
        bus(1'b1, OFS_PERIOD, p);
        // Unmask so the dead band interrupt path is seen by the checker
        bus(1'b1, OFS_IRQ_MASK, 32'h1);
        for (m = 0; m < 3; m++) begin
            hi <= 8'(p + 6);
            lo <= 8'(p + 6);
            bus(1'b1, OFS_FUNCTION, FUNC_DEADBAND | (m << 2));
            bus(1'b1, OFS_CONTROL, 32'h1);
            n0 = n_pri;
            a0 = n_aux;
            repeat (8 * p + 60) @(posedge mclk_in);
            chk("primary rises", n_pri > n0 + 1, 1);
            chk("aux rises", n_aux > a0 + 1, 1);
            data_in <= 1'b1;
            repeat (3) @(posedge mclk_in);
            data_in <= 1'b0;
            bus(1'b0, OFS_CONTROL, 32'h0);
            chk("kill enable", rd[0], m != 1);
        end
        // Reference high shorter than the dead time keeps primary low
        hi <= 8'(p - 1);
        bus(1'b1, OFS_CONTROL, 32'h1);
        // A high half begun with the old length may still raise primary; let it pass
        repeat (2 * p + 14) @(posedge mclk_in);
        n0 = n_pri;
        a0 = n_aux;
        repeat (8 * p + 60) @(posedge mclk_in);
        chk("short high", n_pri - n0, 0);
        chk("long low", n_aux > a0, 1);
        // Firmware-toggled reference
        hi <= 8'h00;
        bus(1'b1, OFS_CONTROL, 32'h1);
        // Parking the neighbour may give one last falling edge; let its phase settle
        repeat (2 * p + 14) @(posedge mclk_in);
        n0 = n_pri;
        a0 = n_aux;
        bus(1'b1, OFS_CONTROL, 32'h9);
        repeat (p + 6) @(posedge mclk_in);
        bus(1'b1, OFS_CONTROL, 32'h1);
        repeat (p + 6) @(posedge mclk_in);
        chk("soft primary", n_pri - n0, 1);
        chk("soft aux", n_aux - a0, 1);
        give_verdict();
    end
endmodule
`default_nettype wire
